// file: verilog/refsel_pkg.sv
// Constants and types shared by the speed reference selector.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package refsel_pkg;

  // ==========================================================
  // Sizes
  localparam int CHANNELS    = 8;
  localparam int TERMINALS   = 8;
  localparam int REF_W       = 16;
  localparam int NUM_PRESETS = 12;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_METHOD = 8'h00;
  localparam logic [7:0] OFF_USER   = 8'h04;
  localparam logic [7:0] OFF_ASSIGN = 8'h08;
  localparam logic [7:0] OFF_MODES  = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_OUTPUT = 8'h14;
  localparam logic [7:0] OFF_PRESET = 8'h40;

  // ==========================================================
  // Field positions and writable masks
  localparam int USER_TWO_LSB   = 8;
  localparam int MODE_LOCAL_LSB = 8;
  localparam int MODE_OVR_LSB   = 16;
  localparam int STAT_ZERO_BIT  = 4;
  localparam int STAT_TALLY_LSB = 8;
  localparam int STAT_CHAN_LSB  = 16;
  localparam logic [31:0] MASK_METHOD = 32'h0000_0003;
  localparam logic [31:0] MASK_USER   = 32'h0000_0F0F;
  localparam logic [31:0] MASK_MODES  = 32'h000F_0F0F;
  localparam logic [31:0] MASK_PRESET = 32'h0000_FFFF;

  // ==========================================================
  // Values after reset
  localparam logic [31:0] RST_METHOD = 32'h0000_0000;
  localparam logic [31:0] RST_USER   = 32'h0000_0201;
  localparam logic [31:0] RST_ASSIGN = 32'h7654_3210;
  localparam logic [31:0] RST_MODES  = 32'h000E_0E0E;
  localparam logic [15:0] RST_PRESET [NUM_PRESETS] = '{
    16'h0400, 16'h0800, 16'h0C00, 16'h1000, 16'h1400, 16'h1800,
    16'h1C00, 16'h2000, 16'h2400, 16'h2800, 16'h2C00, 16'h3000};

  // ==========================================================
  // Speed reference source codes
  localparam logic [3:0] SRC_ZERO     = 4'h0;
  localparam logic [3:0] SRC_PRE_LAST = 4'hC;
  localparam logic [3:0] SRC_EXTERNAL = 4'hD;
  localparam logic [3:0] SRC_SELECTOR = 4'hE;

  typedef enum logic [1:0] {
    METHOD_MUX   = 2'b00,
    METHOD_MULTI = 2'b01,
    METHOD_COUNT = 2'b10,
    METHOD_NONE  = 2'b11
  } method_e;

endpackage

// file: verilog/refsel_if.sv
// Carries selector channel states and the decoded choice between modules.
// Assumes all parties run on the selector clock.
`timescale 1ns/1ps
interface refsel_if;
  logic [7:0]          chan;
  refsel_pkg::method_e method;
  logic [2:0]          slot;
  logic                none;
  logic [3:0]          tally;

  modport router  (output chan);
  modport decoder (input chan, input method, output slot, output none, output tally);
  modport top     (input chan, input slot, input none, input tally, output method);
endinterface

// file: verilog/channel_router.sv
// Routes synchronised terminal inputs onto the eight selector channels.
// Assumes terminals are asynchronous pins and the assignment word is stable.
`timescale 1ns/1ps
module channel_router (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_terms,
  input  wire logic [31:0] i_assign,
  refsel_if.router         sb
);
  logic [7:0] meta;
  logic [7:0] sync;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta <= 8'h00;
      sync <= 8'h00;
    end else begin
      meta <= i_terms;
      sync <= meta;
    end
  end

  // A code with bit 3 set leaves the channel unassigned and reads low.
  for (genvar g = 0; g < refsel_pkg::CHANNELS; g++) begin : g_chan
    wire logic [3:0] pick;
    assign pick       = i_assign[4*g +: 4];
    assign sb.chan[g] = !pick[3] && sync[pick[2:0]];
  end
endmodule

// file: verilog/method_decoder.sv
// Turns channel states into a candidate slot using the configured method.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module method_decoder (
  refsel_if.decoder sb
);
  logic [3:0] tally;
  logic [2:0] top;
  logic       any;
  wire  [2:0] cnt_slot;
  wire        is_multi;
  wire        is_count;

  always_comb begin
    tally = 4'h0;
    top   = 3'h0;
    any   = 1'b0;
    for (int k = 0; k < refsel_pkg::CHANNELS; k++) begin
      tally = tally + {3'h0, sb.chan[k]};
      if (sb.chan[k]) begin
        top = 3'(k);
        any = 1'b1;
      end
    end
  end

  assign is_multi = sb.method == refsel_pkg::METHOD_MULTI;
  assign is_count = sb.method == refsel_pkg::METHOD_COUNT;
  assign cnt_slot = 3'(tally - 4'h1);
  assign sb.tally = tally;
  assign sb.slot  = is_multi ? top : is_count ? cnt_slot : sb.chan[2:0];
  assign sb.none  = (sb.method == refsel_pkg::METHOD_NONE)
                  | (is_multi & !any)
                  | (is_count & !any);
endmodule

// file: verilog/speed_reference_selector.sv
// Speed reference selector: picks one of eight references from terminal
// driven selector channels and offers it to remote, local and override.
// Assumes a classic Wishbone master on the same clock as I_CLOCK.
//
// Summary of operation
// - Output exactly one of eight references, or zero.
// - Six slots are presets, two are user references.
// - Three selection methods chosen by a setting.
// - Each user reference picks any available source.
// - Each channel takes a configurable input terminal.
// - Multiplex: channels 3-2-1 binary code picks slot.
// - Multi-speed: a true channel nominates its reference.
// - Multi-speed: only highest priority channel counts.
// - Multi-speed: no true channel gives zero.
// - Count mode: number of true channels picks.
// - Count mode: zero count gives zero.
// - Output selectable for remote, local and override.
`timescale 1ns/1ps
module speed_reference_selector (
  // Clock and reset
  input  wire logic        I_CLOCK,
  input  wire logic        I_RST,
  // Wishbone slave
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [7:0]  I_WB_ADR,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic [31:0] I_WB_DAT,
  output logic      [31:0] O_WB_DAT,
  output logic             O_WB_ACK,
  // Digital input terminals and external reference
  input  wire logic [7:0]  I_TERMINALS,
  input  wire logic [15:0] I_EXT_REF,
  // Speed references
  output logic      [15:0] O_SPEED_REF,
  output logic             O_SPEED_ZERO,
  output logic      [15:0] O_REMOTE_REF,
  output logic      [15:0] O_LOCAL_REF,
  output logic      [15:0] O_OVERRIDE_REF
);

  // ==========================================================
  // Configuration storage

  logic [31:0] selection_scheme_setting;
  logic [31:0] user_sources;
  logic [31:0] channel_assign;
  logic [31:0] mode_sources;
  logic [15:0] preset [refsel_pkg::NUM_PRESETS];

  refsel_if sb ();

  // ==========================================================
  // Bus decode

  wire        req;
  wire        wr;
  wire        in_preset;
  wire [3:0]  pidx;
  wire        hit_method;
  wire        hit_user;
  wire        hit_assign;
  wire        hit_modes;
  wire [31:0] bytemask;
  wire [31:0] rd_word;
  wire [31:0] status_word;

  assign req        = I_WB_CYC && I_WB_STB;
  // Writes land on the edge where the master sees ack high.
  assign wr         = req && I_WB_WE && O_WB_ACK;
  assign pidx       = I_WB_ADR[5:2];
  assign in_preset  = (I_WB_ADR[7:6] == refsel_pkg::OFF_PRESET[7:6])
                   && (I_WB_ADR[1:0] == 2'b00)
                   && (pidx < 4'(refsel_pkg::NUM_PRESETS));
  assign hit_method = I_WB_ADR == refsel_pkg::OFF_METHOD;
  assign hit_user   = I_WB_ADR == refsel_pkg::OFF_USER;
  assign hit_assign = I_WB_ADR == refsel_pkg::OFF_ASSIGN;
  assign hit_modes  = I_WB_ADR == refsel_pkg::OFF_MODES;

  assign bytemask = {{8{I_WB_SEL[3]}}, {8{I_WB_SEL[2]}},
                     {8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] mask);
    return (old & ~(bytemask & mask)) | (I_WB_DAT & bytemask & mask);
  endfunction

  // ==========================================================
  // Register writes

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      selection_scheme_setting <= refsel_pkg::RST_METHOD;
      user_sources             <= refsel_pkg::RST_USER;
      channel_assign           <= refsel_pkg::RST_ASSIGN;
      mode_sources             <= refsel_pkg::RST_MODES;
    end else if (wr) begin
      if (hit_method)
        selection_scheme_setting <= merge(selection_scheme_setting,
                                          refsel_pkg::MASK_METHOD);
      if (hit_user)
        user_sources <= merge(user_sources, refsel_pkg::MASK_USER);
      if (hit_assign)
        channel_assign <= merge(channel_assign, 32'hFFFF_FFFF);
      if (hit_modes)
        mode_sources <= merge(mode_sources, refsel_pkg::MASK_MODES);
    end
  end

  for (genvar p = 0; p < refsel_pkg::NUM_PRESETS; p++) begin : g_preset
    wire [31:0] merged;
    assign merged = merge({16'h0000, preset[p]}, refsel_pkg::MASK_PRESET);
    always_ff @(posedge I_CLOCK) begin
      if (I_RST)
        preset[p] <= refsel_pkg::RST_PRESET[p];
      else if (wr && in_preset && pidx == 4'(p))
        preset[p] <= merged[15:0];
    end
  end

  // ==========================================================
  // Channel routing and method decoding

  channel_router u_router (
    .i_clk    (I_CLOCK),
    .i_rst    (I_RST),
    .i_terms  (I_TERMINALS),
    .i_assign (channel_assign),
    .sb       (sb)
  );

  method_decoder u_decoder (
    .sb (sb)
  );

  assign sb.method = refsel_pkg::method_e'(selection_scheme_setting[1:0]);

  // ==========================================================
  // Source resolution

  // Codes 1 to 12 are presets one to twelve; unused codes resolve to zero.
  function automatic logic [15:0] src_val(input logic [3:0]  c,
                                          input logic [15:0] sel);
    logic [15:0] v;
    v = 16'h0000;
    if (c != refsel_pkg::SRC_ZERO && c <= refsel_pkg::SRC_PRE_LAST)
      v = preset[c - 4'h1];
    else if (c == refsel_pkg::SRC_EXTERNAL)
      v = I_EXT_REF;
    else if (c == refsel_pkg::SRC_SELECTOR)
      v = sel;
    return v;
  endfunction

  wire [15:0] user1_val;
  wire [15:0] user2_val;
  wire [15:0] cand [refsel_pkg::CHANNELS];
  wire [15:0] next_speed_ref;
  wire        next_speed_zero;

  localparam int USR2 = refsel_pkg::USER_TWO_LSB;

  // A user reference may not point back at the selector; that would be a
  // loop with no defined value, so it reads as zero instead.
  assign user1_val = src_val(user_sources[3:0], 16'h0000);
  assign user2_val = src_val(user_sources[USR2 +: 4], 16'h0000);

  assign cand[0] = user1_val;
  assign cand[1] = user2_val;
  for (genvar k = 2; k < refsel_pkg::CHANNELS; k++) begin : g_cand
    assign cand[k] = preset[k];
  end

  assign next_speed_zero = sb.none;
  assign next_speed_ref  = sb.none ? 16'h0000 : cand[sb.slot];

  // ==========================================================
  // Output registers

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      O_SPEED_REF  <= 16'h0000;
      O_SPEED_ZERO <= 1'b1;
    end else begin
      O_SPEED_REF  <= next_speed_ref;
      O_SPEED_ZERO <= next_speed_zero;
    end
  end

  localparam int LOC = refsel_pkg::MODE_LOCAL_LSB;
  localparam int OVR = refsel_pkg::MODE_OVR_LSB;

  // Each operating mode picks its own source; the selector is code 14.
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      O_REMOTE_REF   <= 16'h0000;
      O_LOCAL_REF    <= 16'h0000;
      O_OVERRIDE_REF <= 16'h0000;
    end else begin
      O_REMOTE_REF   <= src_val(mode_sources[3:0], O_SPEED_REF);
      O_LOCAL_REF    <= src_val(mode_sources[LOC +: 4], O_SPEED_REF);
      O_OVERRIDE_REF <= src_val(mode_sources[OVR +: 4], O_SPEED_REF);
    end
  end

  // ==========================================================
  // Bus reads and acknowledge

  assign status_word = {8'h00, sb.chan, 4'h0, sb.tally,
                        3'h0, sb.none, 1'b0, sb.slot};

  assign rd_word = hit_method ? selection_scheme_setting
                 : hit_user   ? user_sources
                 : hit_assign ? channel_assign
                 : hit_modes  ? mode_sources
                 : (I_WB_ADR == refsel_pkg::OFF_STATUS) ? status_word
                 : (I_WB_ADR == refsel_pkg::OFF_OUTPUT)
                   ? {15'h0000, O_SPEED_ZERO, O_SPEED_REF}
                 : in_preset ? {16'h0000, preset[pidx]}
                 : 32'h0000_0000;

  // Unmapped addresses are acknowledged, read zero and ignore writes.
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h0000_0000;
    end else begin
      O_WB_ACK <= req && !O_WB_ACK;
      O_WB_DAT <= rd_word;
    end
  end

  // ==========================================================
  // Assertions

  // Checks start one edge after reset is released, so that the reset edge
  // itself opens no attempt on outputs that are still held at zero.
  logic armed;

  always_ff @(posedge I_CLOCK) begin
    if (I_RST)
      armed <= 1'b0;
    else
      armed <= 1'b1;
  end

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST || !armed);

  wire is_mux;
  wire is_multi;
  wire is_count;
  assign is_mux   = sb.method == refsel_pkg::METHOD_MUX;
  assign is_multi = sb.method == refsel_pkg::METHOD_MULTI;
  assign is_count = sb.method == refsel_pkg::METHOD_COUNT;

  mux_user_a: assert property (
    is_mux && sb.chan[2:0] == 3'b000 |=> O_SPEED_REF == $past(user1_val))
    else $error("Multiplex code 000 did not give user one.");

  mux_top_a: assert property (
    is_mux && sb.chan[2:0] == 3'b111 |=> O_SPEED_REF == $past(preset[7]))
    else $error("Multiplex code 111 did not give preset eight.");

  mux_mid_a: assert property (
    is_mux && sb.chan[2:0] == 3'b010 |=> O_SPEED_REF == $past(preset[2]))
    else $error("Multiplex code 010 did not give preset three.");

  multi_pick_a: assert property (
    is_multi && sb.chan == 8'h04 |=> O_SPEED_REF == $past(preset[2]))
    else $error("Channel three alone did not give preset three.");

  multi_prio_a: assert property (
    is_multi && sb.chan[7] |=> O_SPEED_REF == $past(preset[7]))
    else $error("Channel eight did not take priority.");

  multi_low_a: assert property (
    is_multi && sb.chan == 8'h03 |=> O_SPEED_REF == $past(user2_val))
    else $error("Channel two did not outrank channel one.");

  multi_zero_a: assert property (
    is_multi && sb.chan == 8'h00 |=> O_SPEED_REF == 16'h0000 && O_SPEED_ZERO)
    else $error("No true channel did not give zero.");

  tally_four_a: assert property (
    is_count && $countones(sb.chan) == 4 |=> O_SPEED_REF == $past(preset[3]))
    else $error("Count of four did not give preset four.");

  tally_one_a: assert property (
    is_count && $countones(sb.chan) == 1 |=> O_SPEED_REF == $past(user1_val))
    else $error("Count of one did not give user one.");

  tally_all_a: assert property (
    is_count && sb.chan == 8'hFF |=> O_SPEED_REF == $past(preset[7]))
    else $error("Count of eight did not give preset eight.");

  none_method_a: assert property (
    sb.method == refsel_pkg::METHOD_NONE |=> O_SPEED_ZERO && O_SPEED_REF == 16'h0000)
    else $error("Method none did not give zero.");

  zero_ref_a: assert property (
    O_SPEED_ZERO |-> O_SPEED_REF == 16'h0000)
    else $error("Zero flag stood with a nonzero reference.");

  tally_zero_a: assert property (
    is_count && sb.chan == 8'h00 |=> O_SPEED_ZERO ##1 O_REMOTE_REF == 16'h0000
      || mode_sources[3:0] != refsel_pkg::SRC_SELECTOR)
    else $error("Count of zero did not give zero.");

  remote_sel_a: assert property (
    mode_sources[3:0] == refsel_pkg::SRC_SELECTOR
      |=> O_REMOTE_REF == $past(O_SPEED_REF))
    else $error("Remote reference did not follow the selector.");

  ovr_ext_a: assert property (
    mode_sources[OVR +: 4] == refsel_pkg::SRC_EXTERNAL
      |=> O_OVERRIDE_REF == $past(I_EXT_REF))
    else $error("Override reference did not follow the external input.");

  chan_route_a: assert property (
    channel_assign[3:0] == 4'h5 && !$past(I_RST, 1) && !$past(I_RST, 2)
      |-> sb.chan[0] == $past(I_TERMINALS[5], 2))
    else $error("Channel one did not follow its terminal.");

  route_off_a: assert property (
    channel_assign[7] |-> !sb.chan[1])
    else $error("Switched off channel two did not read low.");

  write_land_a: assert property (
    wr && hit_modes && I_WB_SEL == 4'hF
      |=> mode_sources == ($past(I_WB_DAT) & refsel_pkg::MASK_MODES))
    else $error("Mode source write did not land.");

  read_out_a: assert property (
    req && !O_WB_ACK && !I_WB_WE && I_WB_ADR == refsel_pkg::OFF_OUTPUT
      |=> O_WB_DAT[15:0] == $past(O_SPEED_REF))
    else $error("Output word read did not show the reference.");

  ack_pulse_a: assert property (
    req && !O_WB_ACK |=> O_WB_ACK ##1 !O_WB_ACK)
    else $error("Bus acknowledge was not a single cycle.");

  cover_multi_c: cover property (is_multi && $countones(sb.chan) > 1);
  cover_tally_c: cover property (is_count && sb.tally == 4'h4);
  cover_mux_c:   cover property (is_mux && sb.chan[2:0] == 3'b111);
  cover_write_c: cover property (wr && hit_method);
  cover_zero_c:  cover property (is_count && O_SPEED_ZERO);

endmodule

// file: test/terminal_model.sv
// Model of the digital input terminals and the external reference source.
// Assumes the bench posts new levels just after a rising clock edge.
`timescale 1ns/1ps
module terminal_model (
  // Clock
  input  wire logic        i_clk,
  // Requested levels
  input  wire logic [7:0]  i_terms_req,
  input  wire logic [15:0] i_ext_req,
  // Pins towards the selector
  output logic      [7:0]  o_terms,
  output logic      [15:0] o_ext
);
  // ==========================================================
  // Pins
  // Contacts settle on a clock edge, so a new level lands one cycle late.
  initial begin
    o_terms = 8'h00;
    o_ext   = 16'h0000;
  end
  always @(posedge i_clk) begin
    o_terms <= i_terms_req;
    o_ext   <= i_ext_req;
  end
endmodule

// file: test/speed_reference_selector_tb_top.sv
// Self-checking bench for the speed reference selector.
// Assumes the Wishbone answer and terminal latencies given by the designer.
`timescale 1ns/1ps
module speed_reference_selector_tb_top;
  logic        clk;
  logic        rst;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic [7:0]  terms_req;
  logic [15:0] ext_req;
  logic [7:0]  terms;
  logic [15:0] ext_ref;
  logic [15:0] speed_ref;
  logic        speed_zero;
  logic [15:0] remote_ref;
  logic [15:0] local_ref;
  logic [15:0] override_ref;
  int          num_errors;
  int          compares;

  // ==========================================================
  // Clock, reset and instances
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  terminal_model terminal_model_inst (.i_clk(clk), .i_terms_req(terms_req),
    .i_ext_req(ext_req), .o_terms(terms), .o_ext(ext_ref));
  speed_reference_selector speed_reference_selector_inst (.I_CLOCK(clk), .I_RST(rst),
    .I_WB_CYC(wb_cyc), .I_WB_STB(wb_stb), .I_WB_WE(wb_we), .I_WB_ADR(wb_adr),
    .I_WB_SEL(wb_sel), .I_WB_DAT(wb_dat), .O_WB_DAT(wb_rdat), .O_WB_ACK(wb_ack),
    .I_TERMINALS(terms), .I_EXT_REF(ext_ref), .O_SPEED_REF(speed_ref),
    .O_SPEED_ZERO(speed_zero), .O_REMOTE_REF(remote_ref), .O_LOCAL_REF(local_ref),
    .O_OVERRIDE_REF(override_ref));

  // ==========================================================
  // Shared tasks
  task automatic report_and_stop();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // The request holds until ack is sampled high; read data is taken there.
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                          input logic [31:0] wdat, output logic [31:0] rdat);
    int n;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= adr;
    wb_sel <= sel;
    wb_dat <= wdat;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1);
    rdat = wb_rdat;
    check("bus ack edges", 32'h0000_0002, 32'(n));
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] d);
    logic [31:0] unused;
    wb_cycle(1'b1, adr, sel, d, unused);
  endtask
  task automatic rd_check(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] got;
    wb_cycle(1'b0, adr, 4'hF, 32'h0000_0000, got);
    check("register word", exp, got);
  endtask
  // With the mode sources at reset all three modes follow the selector.
  task automatic settle_check(input logic [7:0] t, input logic [15:0] exp, input logic z);
    @(posedge clk);
    terms_req <= t;
    repeat (7) @(posedge clk);
    @(negedge clk);
    check("speed ref", {16'h0, exp}, {16'h0, speed_ref});
    check("speed zero", {31'h0, z}, {31'h0, speed_zero});
    check("remote ref", {16'h0, exp}, {16'h0, remote_ref});
    check("local ref", {16'h0, exp}, {16'h0, local_ref});
    check("override ref", {16'h0, exp}, {16'h0, override_ref});
  endtask

  // ==========================================================
  // Scenarios
  task automatic test_reset_values();
    rd_check(refsel_pkg::OFF_METHOD, 32'h0000_0000);
    rd_check(refsel_pkg::OFF_USER, 32'h0000_0201);
    rd_check(refsel_pkg::OFF_ASSIGN, 32'h7654_3210);
    rd_check(refsel_pkg::OFF_MODES, 32'h000E_0E0E);
    rd_check(refsel_pkg::OFF_PRESET, 32'h0000_0400);
    rd_check(8'h6C, 32'h0000_3000);
    wr(8'h30, 4'hF, 32'hFFFF_FFFF);
    rd_check(8'h30, 32'h0000_0000);
    wr(refsel_pkg::OFF_OUTPUT, 4'hF, 32'hFFFF_FFFF);
    rd_check(refsel_pkg::OFF_OUTPUT, 32'h0000_0400);
  endtask
  // Upper channels are driven high to show that only channels 1 to 3 count.
  task automatic test_mux();
    for (int k = 0; k < 8; k++) begin
      settle_check(8'(k) | 8'hF8, 16'(k + 1) * 16'h0400, 1'b0);
    end
  endtask
  task automatic test_multi();
    wr(refsel_pkg::OFF_METHOD, 4'hF, 32'h0000_0001);
    for (int n = 1; n <= 8; n++) begin
      settle_check(8'h01 << (n - 1), 16'(n) * 16'h0400, 1'b0);
    end
    settle_check(8'h85, 16'h2000, 1'b0);
    settle_check(8'h06, 16'h0C00, 1'b0);
    settle_check(8'h00, 16'h0000, 1'b1);
  endtask
  task automatic test_count();
    wr(refsel_pkg::OFF_METHOD, 4'hF, 32'h0000_0002);
    for (int k = 0; k <= 8; k++) begin
      settle_check(8'hFF << (8 - k), 16'(k) * 16'h0400, k == 0);
    end
    settle_check(8'hD4, 16'h1000, 1'b0);
    wr(refsel_pkg::OFF_METHOD, 4'hF, 32'h0000_0003);
    settle_check(8'h07, 16'h0000, 1'b1);
    wr(refsel_pkg::OFF_METHOD, 4'hF, 32'h0000_0000);
  endtask
  task automatic test_user_refs();
    ext_req <= 16'h5A3C;
    wr(refsel_pkg::OFF_USER, 4'hF, 32'h0000_0D0C);
    settle_check(8'h00, 16'h3000, 1'b0);
    settle_check(8'h01, 16'h5A3C, 1'b0);
    wr(refsel_pkg::OFF_USER, 4'hF, 32'h0000_0201);
    wr(8'h48, 4'h1, 32'h0000_FFFF);
    rd_check(8'h48, 32'h0000_0CFF);
    settle_check(8'h02, 16'h0CFF, 1'b0);
    wr(8'h48, 4'hF, 32'h0000_0C00);
  endtask
  // Channel one moves to terminal 5 and channel two is switched off.
  task automatic test_routing();
    wr(refsel_pkg::OFF_ASSIGN, 4'hF, 32'h7654_3285);
    settle_check(8'h20, 16'h0800, 1'b0);
    settle_check(8'h02, 16'h0400, 1'b0);
    settle_check(8'h04, 16'h1400, 1'b0);
    wr(refsel_pkg::OFF_ASSIGN, 4'hF, 32'h7654_3210);
  endtask
  task automatic test_modes();
    wr(refsel_pkg::OFF_MODES, 4'hF, 32'h000D_0C01);
    repeat (4) @(posedge clk);
    @(negedge clk);
    check("remote ref", 32'h0000_0400, {16'h0, remote_ref});
    check("local ref", 32'h0000_3000, {16'h0, local_ref});
    check("override ref", 32'h0000_5A3C, {16'h0, override_ref});
    wr(refsel_pkg::OFF_MODES, 4'hF, 32'h000E_0E0E);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    rst = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_dat = 32'h0000_0000;
    terms_req = 8'h00;
    ext_req = 16'h0000;
    num_errors = 0;
    compares = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    test_reset_values();
    test_mux();
    test_multi();
    test_count();
    test_user_refs();
    test_routing();
    test_modes();
    report_and_stop();
  end
  // The tests need about four hundred cycles; twenty thousand means a hang.
  initial begin
    #100000;
    num_errors++;
    $display("watchdog expired");
    report_and_stop();
  end
endmodule
